// ==== include/tcic_defines.svh ====
// Register offsets, field positions, reset values and widths of the timer capture block
`ifndef TCIC_DEFINES_SVH
`define TCIC_DEFINES_SVH

// Register byte offsets on the APB bus
`define TCIC_OFS_CTRL 12'h000
`define TCIC_OFS_EDGE 12'h004
`define TCIC_OFS_MASK 12'h008
`define TCIC_OFS_FLAG 12'h00c
`define TCIC_OFS_OVF 12'h010
`define TCIC_OFS_COUNT 12'h014
`define TCIC_OFS_CAP1 12'h018
`define TCIC_OFS_CAP2 12'h01c
`define TCIC_OFS_CAP3 12'h020
`define TCIC_OFS_SHARED 12'h024
`define TCIC_OFS_CMP1 12'h028
`define TCIC_OFS_CMP2 12'h02c
`define TCIC_OFS_CMP3 12'h030
`define TCIC_OFS_CMP4 12'h034
`define TCIC_OFS_OC1_MASK 12'h038
`define TCIC_OFS_OC1_DATA 12'h03c
`define TCIC_OFS_PORT 12'h040

// Control register fields
`define TCIC_CTRL_PRESCALE_LO 0
`define TCIC_CTRL_PRESCALE_HI 1
`define TCIC_CTRL_SHARED_SEL 2
`define TCIC_CTRL_BIT3_DIR 3
`define TCIC_CTRL_TOGGLE_LO 4
`define TCIC_CTRL_TOGGLE_HI 7

// Edge control field positions per capture channel
`define TCIC_EDGE_POS_CH1 4
`define TCIC_EDGE_POS_CH2 2
`define TCIC_EDGE_POS_CH3 0
`define TCIC_EDGE_POS_CH4 6

// Flag and mask bit positions
`define TCIC_FLAG_CAP_LO 0
`define TCIC_FLAG_SHARED 3
`define TCIC_FLAG_OC1 4
`define TCIC_FLAG_OC4 7
`define TCIC_OVF_ENABLE 0
`define TCIC_OVF_FLAG 1

// Shared pin and upper port pins
`define TCIC_SHARED_PIN 3
`define TCIC_UPPER_LO 3
`define TCIC_UPPER_HI 7

// Reset values and counter maximum
`define TCIC_RST_BYTE 8'h00
`define TCIC_RST_COUNT 16'h0000
`define TCIC_RST_CMP 16'hffff
`define TCIC_COUNT_MAX 16'hffff

// Prescale reload values: ratio minus one
`define TCIC_DIV1_LOAD 4'h0
`define TCIC_DIV4_LOAD 4'h3
`define TCIC_DIV8_LOAD 4'h7
`define TCIC_DIV16_LOAD 4'hf

`endif

// ==== include/tcic_pkg.sv ====
// Types shared by the timer capture block
package tcic_pkg;

  // Prescale ratio codes
  typedef enum logic [1:0] {
    TCIC_DIV1,
    TCIC_DIV4,
    TCIC_DIV8,
    TCIC_DIV16
  } tcic_prescale_t;

  // Capture edge selection codes
  typedef enum logic [1:0] {
    TCIC_EDGE_OFF,
    TCIC_EDGE_RISE,
    TCIC_EDGE_FALL,
    TCIC_EDGE_ANY
  } tcic_edge_t;

endpackage

// ==== verilog/tcic_prescaler.sv ====
// Programmable prescaler that paces the free-running counter
`include "tcic_defines.svh"

module tcic_prescaler (
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Asynchronous reset, active low
  input wire tcic_pkg::tcic_prescale_t i_ratio, // Selected divide ratio
  output logic o_tick // One-cycle count advance pulse
);

  logic [3:0] div_count; // Cycles left until the next tick
  logic [3:0] reload; // Reload value for the chosen ratio

  // Map the ratio code onto a reload value
  always_comb begin
    unique case (i_ratio)
      tcic_pkg::TCIC_DIV1: reload = `TCIC_DIV1_LOAD;
      tcic_pkg::TCIC_DIV4: reload = `TCIC_DIV4_LOAD;
      tcic_pkg::TCIC_DIV8: reload = `TCIC_DIV8_LOAD;
      tcic_pkg::TCIC_DIV16: reload = `TCIC_DIV16_LOAD;
    endcase
  end

  // Down counter; a ratio change takes effect at the next reload
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_count <= 4'h0;
    end else if (div_count == 4'h0) begin
      div_count <= reload;
    end else begin
      div_count <= div_count - 4'h1;
    end
  end

  // Tick when the down counter is spent
  assign o_tick = (div_count == 4'h0);

endmodule

// ==== verilog/tcic_edge_detect.sv ====
// Edge detector for one input capture channel
module tcic_edge_detect (
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Asynchronous reset, active low
  input wire logic i_level, // Synchronised pin level
  input wire tcic_pkg::tcic_edge_t i_mode, // Edge selection
  output logic o_event // One-cycle capture request
);

  logic prev_level; // Level seen one cycle earlier
  logic rise; // Rising edge this cycle
  logic fall; // Falling edge this cycle

  // Remember the previous level
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= i_level;
    end
  end

  assign rise = i_level & ~prev_level;
  assign fall = ~i_level & prev_level;

  // Select which edges count as a capture
  always_comb begin
    unique case (i_mode)
      tcic_pkg::TCIC_EDGE_OFF: o_event = 1'b0;
      tcic_pkg::TCIC_EDGE_RISE: o_event = rise;
      tcic_pkg::TCIC_EDGE_FALL: o_event = fall;
      tcic_pkg::TCIC_EDGE_ANY: o_event = rise | fall;
    endcase
  end

endmodule

// ==== verilog/tcic_top.sv ====
// Main timer: free-running counter, input captures, output compares and APB registers
//
// Added by the designer: the APB register port and the register addresses.
`include "tcic_defines.svh"

module tcic_top (
  input wire logic I_SYS_CLK, // System clock, 10 MHz
  input wire logic I_RSTN, // Asynchronous reset, active low
  input wire logic I_PSEL, // APB select
  input wire logic I_PENABLE, // APB access phase
  input wire logic I_PWRITE, // APB write direction
  input wire logic [11:0] I_PADDR, // APB byte address
  input wire logic [31:0] I_PWDATA, // APB write data
  output logic [31:0] O_PRDATA, // APB read data
  output logic O_PREADY, // APB ready, always high
  output logic O_PSLVERR, // APB error on unmapped address
  input wire logic [7:0] I_PORT_A, // Port A pin levels
  output logic [7:0] O_PORT_A, // Port A output levels
  output logic [7:0] O_PORT_A_OEN, // Port A output enables, low drives
  output logic [8:0] O_IRQ // Per-function interrupt requests
);

  // Bus decode
  logic wr_en; // Write in access phase
  logic rd_en; // Read in access phase
  logic [7:0] wbyte; // Low byte of write data
  logic mapped; // Address hits a register

  // Software registers
  logic [7:0] ctrl; // Prescale, shared select, bit-3 direction, toggle enables
  logic [7:0] capture_edge_control; // Edge fields of four capture channels
  logic [7:0] timer_mask_one; // Capture and compare interrupt enables
  logic [7:0] timer_flags_one; // Capture and compare flags
  logic ovf_enable; // Overflow interrupt enable
  logic ovf_flag; // Overflow flag
  logic [15:0] free_running_count; // Main counter
  logic [15:0] capture [0:2]; // Dedicated capture registers
  logic [15:0] shared_capture_compare_reg; // Fourth capture or fifth compare
  logic [15:0] compare [0:3]; // Compare registers one to four
  logic [7:3] oc1_mask; // Upper pins driven by the first compare
  logic [7:3] oc1_data; // Levels placed by the first compare
  logic [7:3] gpio_out; // General-purpose output latch
  logic [7:3] oc_level; // Levels set by compare actions

  // Internal signals
  logic tick; // Counter advance pulse
  logic count_moved; // Counter changed last cycle
  logic [15:0] count_hold [0:3]; // Count held for a pending transfer
  logic [3:0] pending; // Transfer waiting for its register
  logic [3:0] hold_off; // Read of this capture this cycle
  logic [3:0] cap_event; // Capture request per channel
  logic [3:0] cap_level; // Level fed to each edge detector
  logic [7:0] sync1; // First synchroniser stage
  logic [7:0] pin_sync; // Synchronised pin levels
  logic [4:0] match; // Compare matches, first to fifth
  logic [4:0] cmp_inhibit; // Compare held off after a write
  logic [7:3] oc_owned; // Upper pins owned by compares
  logic shared_capture; // Shared channel is in capture mode

  assign shared_capture = ctrl[`TCIC_CTRL_SHARED_SEL];

  // APB decode: zero-wait slave
  assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_en = I_PSEL & I_PENABLE & ~I_PWRITE;
  assign wbyte = I_PWDATA[7:0];
  assign O_PREADY = 1'b1;

  // Pin synchroniser, two flops per pin
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sync1 <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      sync1 <= I_PORT_A;
      pin_sync <= sync1;
    end
  end

  // Prescaler for the counter
  tcic_prescaler u_prescaler (
    .i_clk(I_SYS_CLK),
    .i_rstn(I_RSTN),
    .i_ratio(tcic_pkg::tcic_prescale_t'(ctrl[`TCIC_CTRL_PRESCALE_HI:`TCIC_CTRL_PRESCALE_LO])),
    .o_tick(tick)
  );

  // Free-running counter; no bus path reaches it
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      free_running_count <= `TCIC_RST_COUNT;
    end else if (tick) begin
      free_running_count <= free_running_count + 16'h0001;
    end
  end

  // Mark the cycle after a count change for the comparators
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      count_moved <= 1'b0;
    end else begin
      count_moved <= tick;
    end
  end

  // Overflow enable and flag; the set wins over a clear
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ovf_enable <= 1'b0;
      ovf_flag <= 1'b0;
    end else begin
      if (wr_en && I_PADDR == `TCIC_OFS_OVF) begin
        ovf_enable <= wbyte[`TCIC_OVF_ENABLE];
      end
      if (tick && free_running_count == `TCIC_COUNT_MAX) begin
        ovf_flag <= 1'b1;
      end else if (wr_en && I_PADDR == `TCIC_OFS_OVF && wbyte[`TCIC_OVF_FLAG]) begin
        ovf_flag <= 1'b0;
      end
    end
  end

  // Control, edge, mask and first-compare configuration registers
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl <= `TCIC_RST_BYTE;
      capture_edge_control <= `TCIC_RST_BYTE;
      timer_mask_one <= `TCIC_RST_BYTE;
      oc1_mask <= 5'h00;
      oc1_data <= 5'h00;
    end else if (wr_en) begin
      unique case (I_PADDR)
        `TCIC_OFS_CTRL: ctrl <= wbyte;
        `TCIC_OFS_EDGE: capture_edge_control <= wbyte;
        `TCIC_OFS_MASK: timer_mask_one <= wbyte;
        `TCIC_OFS_OC1_MASK: oc1_mask <= wbyte[7:3];
        `TCIC_OFS_OC1_DATA: oc1_data <= wbyte[7:3];
        default: begin
        end
      endcase
    end
  end

  // Capture sources: shared channel sees the driven level when it is an output
  assign cap_level[2:0] = pin_sync[2:0];
  assign cap_level[3] = ctrl[`TCIC_CTRL_BIT3_DIR] ? gpio_out[`TCIC_SHARED_PIN] : pin_sync[3];

  // Read hold-off per capture register
  assign hold_off[0] = rd_en && I_PADDR == `TCIC_OFS_CAP1;
  assign hold_off[1] = rd_en && I_PADDR == `TCIC_OFS_CAP2;
  assign hold_off[2] = rd_en && I_PADDR == `TCIC_OFS_CAP3;
  assign hold_off[3] = rd_en && I_PADDR == `TCIC_OFS_SHARED;

  // Per-channel edge detection and pending transfer
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_cap
      localparam int EPOS = (ch == 0) ? `TCIC_EDGE_POS_CH1 : (ch == 1) ? `TCIC_EDGE_POS_CH2 :
                            (ch == 2) ? `TCIC_EDGE_POS_CH3 : `TCIC_EDGE_POS_CH4;
      logic raw_event; // Edge seen before the mode gate

      tcic_edge_detect u_edge (
        .i_clk(I_SYS_CLK),
        .i_rstn(I_RSTN),
        .i_level(cap_level[ch]),
        .i_mode(tcic_pkg::tcic_edge_t'(capture_edge_control[EPOS+1:EPOS])),
        .o_event(raw_event)
      );

      // The shared channel captures only in capture mode
      if (ch == 3) begin : g_shared
        assign cap_event[ch] = raw_event & shared_capture;
      end else begin : g_dedicated
        assign cap_event[ch] = raw_event;
      end

      // Hold the count at the event; transfer when no read blocks it
      always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          pending[ch] <= 1'b0;
          count_hold[ch] <= `TCIC_RST_COUNT;
        end else if (cap_event[ch]) begin
          pending[ch] <= 1'b1;
          count_hold[ch] <= free_running_count;
        end else if (!hold_off[ch]) begin
          pending[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // Dedicated capture registers are left alone by reset
  always_ff @(posedge I_SYS_CLK) begin
    for (int i = 0; i < 3; i++) begin
      if (pending[i] && !hold_off[i]) begin
        capture[i] <= count_hold[i];
      end
    end
  end

  // Shared register: compare value by software, or capture latch
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      shared_capture_compare_reg <= `TCIC_RST_CMP;
    end else if (shared_capture) begin
      if (pending[3] && !hold_off[3]) begin
        shared_capture_compare_reg <= count_hold[3];
      end
    end else if (wr_en && I_PADDR == `TCIC_OFS_SHARED) begin
      shared_capture_compare_reg <= I_PWDATA[15:0];
    end
  end

  // Compare registers one to four
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      for (int i = 0; i < 4; i++) begin
        compare[i] <= `TCIC_RST_CMP;
      end
    end else if (wr_en) begin
      for (int i = 0; i < 4; i++) begin
        if (I_PADDR == `TCIC_OFS_CMP1 + 12'(4 * i)) begin
          compare[i] <= I_PWDATA[15:0];
        end
      end
    end
  end

  // A compare write holds that comparator off for one cycle
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cmp_inhibit <= 5'h00;
    end else begin
      for (int i = 0; i < 4; i++) begin
        cmp_inhibit[i] <= wr_en && I_PADDR == `TCIC_OFS_CMP1 + 12'(4 * i);
      end
      cmp_inhibit[4] <= wr_en && I_PADDR == `TCIC_OFS_SHARED;
    end
  end

  // Match once per count value, in the cycle after the count moves
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      match[i] = count_moved && !cmp_inhibit[i] && compare[i] == free_running_count;
    end
    match[4] = count_moved && !cmp_inhibit[4] && !shared_capture &&
               shared_capture_compare_reg == free_running_count;
  end

  // Flags: hardware set wins over a write-one clear
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      timer_flags_one <= `TCIC_RST_BYTE;
    end else begin
      for (int i = 0; i < 8; i++) begin
        logic set_bit; // Hardware event for this flag
        set_bit = 1'b0;
        if (i < 3) begin
          set_bit = cap_event[i];
        end else if (i == `TCIC_FLAG_SHARED) begin
          set_bit = cap_event[3] | match[4];
        end else begin
          set_bit = match[i - `TCIC_FLAG_OC1];
        end
        if (set_bit) begin
          timer_flags_one[i] <= 1'b1;
        end else if (wr_en && I_PADDR == `TCIC_OFS_FLAG && wbyte[i]) begin
          timer_flags_one[i] <= 1'b0;
        end
      end
    end
  end

  // Separate request line per function
  assign O_IRQ[7:0] = timer_flags_one & timer_mask_one;
  assign O_IRQ[8] = ovf_flag & ovf_enable;

  // Pins owned by a compare: first-compare mask or a toggle enable; pin 3 only outside capture mode
  always_comb begin
    oc_owned = oc1_mask;
    oc_owned[6] = oc_owned[6] | ctrl[`TCIC_CTRL_TOGGLE_HI];
    oc_owned[5] = oc_owned[5] | ctrl[`TCIC_CTRL_TOGGLE_HI-1];
    oc_owned[4] = oc_owned[4] | ctrl[`TCIC_CTRL_TOGGLE_LO+1];
    oc_owned[3] = (oc_owned[3] | ctrl[`TCIC_CTRL_TOGGLE_LO]) & ~shared_capture;
  end

  // General-purpose latch ignores bits owned by compares
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      gpio_out <= 5'h00;
    end else if (wr_en && I_PADDR == `TCIC_OFS_PORT) begin
      for (int b = `TCIC_UPPER_LO; b <= `TCIC_UPPER_HI; b++) begin
        if (!oc_owned[b]) begin
          gpio_out[b] <= wbyte[b];
        end
      end
    end
  end

  // Compare pin actions: toggles on pins 6..3, first compare forces its mask
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      oc_level <= 5'h00;
    end else begin
      for (int b = `TCIC_UPPER_LO; b <= `TCIC_UPPER_HI; b++) begin
        if (match[0] && oc1_mask[b]) begin
          oc_level[b] <= oc1_data[b];
        end else if (b < `TCIC_UPPER_HI && match[7 - b] && ctrl[b + 1]) begin
          oc_level[b] <= ~oc_level[b];
        end
      end
    end
  end

  // Pin drive: low pins are inputs, pin 3 drives when its direction bit is set or a compare owns it
  always_comb begin
    O_PORT_A = 8'h00;
    O_PORT_A_OEN = 8'hff;
    for (int b = `TCIC_UPPER_LO; b <= `TCIC_UPPER_HI; b++) begin
      O_PORT_A[b] = oc_owned[b] ? oc_level[b] : gpio_out[b];
      O_PORT_A_OEN[b] = 1'b0;
    end
    O_PORT_A_OEN[`TCIC_SHARED_PIN] = ~(ctrl[`TCIC_CTRL_BIT3_DIR] | oc_owned[3]);
  end

  // Read mux; unmapped addresses read zero with an error
  always_comb begin
    O_PRDATA = 32'h0000_0000;
    mapped = 1'b1;
    unique case (I_PADDR)
      `TCIC_OFS_CTRL: O_PRDATA[7:0] = ctrl;
      `TCIC_OFS_EDGE: O_PRDATA[7:0] = capture_edge_control;
      `TCIC_OFS_MASK: O_PRDATA[7:0] = timer_mask_one;
      `TCIC_OFS_FLAG: O_PRDATA[7:0] = timer_flags_one;
      `TCIC_OFS_OVF: O_PRDATA[1:0] = {ovf_flag, ovf_enable};
      `TCIC_OFS_COUNT: O_PRDATA[15:0] = free_running_count;
      `TCIC_OFS_CAP1: O_PRDATA[15:0] = capture[0];
      `TCIC_OFS_CAP2: O_PRDATA[15:0] = capture[1];
      `TCIC_OFS_CAP3: O_PRDATA[15:0] = capture[2];
      `TCIC_OFS_SHARED: O_PRDATA[15:0] = shared_capture_compare_reg;
      `TCIC_OFS_CMP1: O_PRDATA[15:0] = compare[0];
      `TCIC_OFS_CMP2: O_PRDATA[15:0] = compare[1];
      `TCIC_OFS_CMP3: O_PRDATA[15:0] = compare[2];
      `TCIC_OFS_CMP4: O_PRDATA[15:0] = compare[3];
      `TCIC_OFS_OC1_MASK: O_PRDATA[7:3] = oc1_mask;
      `TCIC_OFS_OC1_DATA: O_PRDATA[7:3] = oc1_data;
      `TCIC_OFS_PORT: O_PRDATA[7:0] = pin_sync;
      default: mapped = 1'b0;
    endcase
  end

  // Error only during the access phase of an unmapped transfer
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;

endmodule

// ==== tb/tcic_pin_model.sv ====
// Pin model: external event sources on port A, resolved against the block's drivers
module tcic_pin_model (
  input wire logic [3:0] i_drive, // Levels the outside world puts on pins 3:0
  input wire logic [7:0] i_out, // Block output levels
  input wire logic [7:0] i_oen, // Block output enables, low drives
  output logic [7:0] o_pin // Resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // Block wins where it drives; undriven pins 3:0 take the outside level, undriven pins 7:4 the inverse of the block output level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!i_oen[i]) begin
        o_pin[i] = i_out[i];
      end else if (i < 4) begin
        o_pin[i] = i_drive[i];
      end else begin
        o_pin[i] = ~i_out[i];
      end
    end
  end
endmodule

// ==== tb/tcic_top_sva.sv ====
// Port-level checker for the timer capture block
`include "tcic_defines.svh"
module tcic_top_sva (
  input wire logic I_SYS_CLK, // System clock
  input wire logic I_RSTN, // Reset, active low
  input wire logic I_PSEL, // APB select
  input wire logic I_PENABLE, // APB access phase
  input wire logic I_PWRITE, // APB direction
  input wire logic [11:0] I_PADDR, // APB address
  input wire logic O_PSLVERR, // APB error
  input wire logic [7:0] I_PORT_A, // Pin levels
  input wire logic [7:0] O_PORT_A, // Output levels
  input wire logic [7:0] O_PORT_A_OEN, // Output enables
  input wire logic [8:0] O_IRQ // Requests
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  // Write access seen on the bus
  sequence s_wr;
    I_PSEL && I_PENABLE && I_PWRITE;
  endsequence
  // A capture request appears with no register write behind it
  sequence s_cap_rise;
    $rose(|O_IRQ[2:0]) && !$past(I_PSEL && I_PENABLE && I_PWRITE);
  endsequence
  property p_reset_state;
    disable iff (1'b0) !I_RSTN |-> O_IRQ == 9'h000 && O_PORT_A_OEN == 8'h0f;
  endproperty
  property p_inputs;
    O_PORT_A_OEN[2:0] == 3'h7 && O_PORT_A[2:0] == 3'h0;
  endproperty
  property p_upper_out;
    O_PORT_A_OEN[7:4] == 4'h0;
  endproperty
  property p_cap_cause;
    s_cap_rise |-> $past(I_PORT_A[2:0], 2) != $past(I_PORT_A[2:0], 6);
  endproperty
  property p_cap_sync;
    s_cap_rise |-> $past(I_PORT_A[2:0], 1) == $past(I_PORT_A[2:0], 2);
  endproperty
  property p_irq_hold;
    (|(~O_IRQ[7:0] & $past(O_IRQ[7:0]))) |-> $past(I_PSEL && I_PENABLE && I_PWRITE);
  endproperty
  property p_ovf_hold;
    $fell(O_IRQ[8]) |-> $past(I_PSEL && I_PENABLE && I_PWRITE);
  endproperty
  property p_count_mapped;
    s_wr and I_PADDR == `TCIC_OFS_COUNT |-> !O_PSLVERR;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  a_inputs: assert property (p_inputs) else $error("capture pins driven");
  a_upper_out: assert property (p_upper_out) else $error("upper pins not outputs");
  a_cap_cause: assert property (p_cap_cause) else $error("capture without pin edge");
  a_cap_sync: assert property (p_cap_sync) else $error("capture faster than sync");
  a_irq_hold: assert property (p_irq_hold) else $error("flag lost without write");
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost without write");
  a_count_mapped: assert property (p_count_mapped) else $error("count write errored");
endmodule
bind tcic_top tcic_top_sva tcic_top_sva_inst (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PSLVERR(O_PSLVERR),
  .I_PORT_A(I_PORT_A), .O_PORT_A(O_PORT_A), .O_PORT_A_OEN(O_PORT_A_OEN), .O_IRQ(O_IRQ));

// ==== tb/testbench.sv ====
// Testbench: APB register tests with pin stimulus for the timer capture block
`include "tcic_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0; // System clock
  logic rstn = 1'b0; // Reset, active low
  logic psel = 1'b0; // APB select
  logic penable = 1'b0; // APB access phase
  logic pwrite = 1'b0; // APB direction
  logic [11:0] paddr = 12'h000; // APB address
  logic [31:0] pwdata = 32'h0; // APB write data
  logic [31:0] prdata; // APB read data
  logic pready; // APB ready
  logic pslverr; // APB error
  logic [7:0] pin; // Resolved pins
  logic [7:0] pout; // Block outputs
  logic [7:0] poen; // Block enables
  logic [8:0] irq; // Requests
  logic [3:0] drive = 4'h0; // External pin levels
  logic [31:0] rv; // Last read data
  logic re; // Last read error
  logic [31:0] a; // Scratch value
  int fails = 0; // Mismatches
  int cmp_count = 0; // Comparisons
  int div[4] = '{1, 4, 8, 16}; // Prescale ratios
  always #50 clk = ~clk; // 10 MHz
  tcic_top tcic_top_inst (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_PORT_A(pin), .O_PORT_A(pout), .O_PORT_A_OEN(poen), .O_IRQ(irq));
  tcic_pin_model tcic_pin_model_inst (.i_drive(drive), .i_out(pout), .i_oen(poen), .o_pin(pin));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for ready under a bound
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0);
    chk(rv, exp);
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("mismatches=%0d comparisons=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog sized for one counter wrap plus the register tests
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(`TCIC_OFS_CTRL, 32'h0);
    rd(`TCIC_OFS_EDGE, 32'h0);
    rd(`TCIC_OFS_FLAG, 32'h0);
    rd(`TCIC_OFS_SHARED, 32'hffff);
    chk(32'(poen), 32'h0f);
    // Count advance over 32 cycles per ratio, with a write to the count in between
    for (int k = 0; k < 4; k++) begin
      wr(`TCIC_OFS_CTRL, 32'(k));
      repeat (20) @(posedge clk);
      bus(1'b0, `TCIC_OFS_COUNT, 32'h0);
      a = rv;
      wr(`TCIC_OFS_COUNT, 32'h0);
      repeat (26) @(posedge clk);
      bus(1'b0, `TCIC_OFS_COUNT, 32'h0);
      chk(32'(rv[15:0] - a[15:0]), 32'(32 / div[k]));
    end
    // Every edge mode on channels 1..3 at once, rising then falling
    wr(`TCIC_OFS_CTRL, 32'h0);
    wr(`TCIC_OFS_MASK, 32'hff);
    for (int m = 0; m < 4; m++) begin
      wr(`TCIC_OFS_EDGE, 32'(m * 21));
      wr(`TCIC_OFS_FLAG, 32'hff);
      drive <= 4'h7;
      repeat (6) @(posedge clk);
      rd(`TCIC_OFS_FLAG, (m % 2) ? 32'h7 : 32'h0);
      chk(32'(irq[2:0]), (m % 2) ? 32'h7 : 32'h0);
      wr(`TCIC_OFS_FLAG, 32'hff);
      drive <= 4'h0;
      repeat (6) @(posedge clk);
      rd(`TCIC_OFS_FLAG, (m > 1) ? 32'h7 : 32'h0);
    end
    bus(1'b0, `TCIC_OFS_CAP1, 32'h0);
    a = rv;
    rd(`TCIC_OFS_CAP2, a);
    rd(`TCIC_OFS_CAP3, a);
    bus(1'b0, `TCIC_OFS_COUNT, 32'h0);
    chk(32'((rv[15:0] - a[15:0]) inside {[16'd5:16'd30]}), 32'h1);
    // Live pin levels
    drive <= 4'h5;
    repeat (4) @(posedge clk);
    bus(1'b0, `TCIC_OFS_PORT, 32'h0);
    chk(32'(rv[2:0]), 32'h5);
    drive <= 4'h0;
    // Shared channel as compare, then as capture fed by software writes
    wr(`TCIC_OFS_SHARED, 32'h1111);
    rd(`TCIC_OFS_SHARED, 32'h1111);
    wr(`TCIC_OFS_CTRL, 32'h0c);
    wr(`TCIC_OFS_EDGE, 32'hc0);
    wr(`TCIC_OFS_FLAG, 32'hff);
    wr(`TCIC_OFS_SHARED, 32'h2222);
    rd(`TCIC_OFS_SHARED, 32'h1111);
    wr(`TCIC_OFS_PORT, 32'h08);
    repeat (4) @(posedge clk);
    rd(`TCIC_OFS_FLAG, 32'h08);
    chk(32'(pout[`TCIC_SHARED_PIN]), 32'h1);
    bus(1'b0, 12'hffc, 32'h0);
    chk(32'(re), 32'h1);
    // Full wrap at divide by one
    wr(`TCIC_OFS_CTRL, 32'h0);
    wr(`TCIC_OFS_OVF, 32'h1);
    wr(`TCIC_OFS_OC1_MASK, 32'h80);
    wr(`TCIC_OFS_OC1_DATA, 32'h80);
    for (int i = 0; i < 70000 && irq[8] !== 1'b1; i++) @(posedge clk);
    bus(1'b0, `TCIC_OFS_COUNT, 32'h0);
    chk(32'(rv < 32'd16), 32'h1);
    rd(`TCIC_OFS_OVF, 32'h3);
    rd(`TCIC_OFS_FLAG, 32'hf8);
    chk(32'(pout[7]), 32'h1);
    // Second reset keeps capture contents, restarts count
    bus(1'b0, `TCIC_OFS_CAP1, 32'h0);
    a = rv;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(`TCIC_OFS_CAP1, a);
    bus(1'b0, `TCIC_OFS_COUNT, 32'h0);
    chk(32'(rv < 32'd8), 32'h1);
    rd(`TCIC_OFS_EDGE, 32'h0);
    close_out();
  end
endmodule
